// *** rtl/haptic_pkg.sv ***
package haptic_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_ACT      = 8'h04;
    localparam logic [7:0] OFF_VLIM     = 8'h08;
    localparam logic [7:0] OFF_ILIM     = 8'h0c;
    localparam logic [7:0] OFF_IMPED    = 8'h10;
    localparam logic [7:0] OFF_PER      = 8'h14;
    localparam logic [7:0] OFF_STATUS   = 8'h18;
    localparam logic [7:0] OFF_BEMF     = 8'h1c;
    localparam logic [7:0] OFF_WBASE    = 8'h20;
    localparam logic [7:0] OFF_MODE     = 8'h24;
    localparam logic [7:0] OFF_WMEM     = 8'h40;
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int CTRL_TRACK      = 0;
    localparam int CTRL_AUTOSCALE  = 1;
    localparam int CTRL_FORCE_ON   = 2;
    localparam int CTRL_OVERDRIVE  = 3;
    localparam int CTRL_BRAKE      = 4;
    localparam int CTRL_ACCESS     = 5;
    // ------------------------------------------------------------
    // reset values and geometry
    // ------------------------------------------------------------
    localparam logic [5:0]  CTRL_RST     = 6'h00;
    localparam logic [14:0] PER_RST      = 15'h0ea6; // 3750 counts, 200 Hz
    localparam int          WMEM_DEPTH   = 100;
    localparam logic [7:0]  WMEM_BASE    = 8'h10;    // entry 0 location
    localparam int          WMEM_AW      = 7;
    // ------------------------------------------------------------
    // period limits in 1333.32 ns units
    // ------------------------------------------------------------
    localparam logic [14:0] PER_50HZ     = 15'h3a98; // 15000
    localparam logic [14:0] PER_300HZ    = 15'h09c4; // 2500
    localparam logic [14:0] PER_25HZ     = 15'h7530; // 30000
    localparam logic [14:0] PER_1000HZ   = 15'h02ee; // 750
    localparam int          LOCK_TOL     = 8;        // lock band in counts
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS      = 20;
    localparam int BOOT_NS     = 1500000;
    localparam int BOOT_CYCLES = (BOOT_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {
        MODE_INACTIVE, MODE_DIRECT, MODE_REG_PLAY, MODE_EDGE_PLAY
    } play_mode_t;
    typedef enum logic [1:0] {ST_BOOT, ST_INACTIVE, ST_ACTIVE} dev_state_t;
endpackage

// *** rtl/tracker_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface tracker_if;
    logic        enable;
    logic        autoscale;
    logic        force_on;
    logic        wideband;
    logic [14:0] nominal;
    logic [14:0] measured;
    logic        meas_valid;
    logic [14:0] period;
    logic        locked;
    logic        range_fault;
    logic [2:0]  gain_shift;
    modport ctl (output enable, autoscale, force_on, wideband, nominal,
                 measured, meas_valid,
                 input period, locked, range_fault, gain_shift);
    modport trk (input enable, autoscale, force_on, wideband, nominal,
                 measured, meas_valid,
                 output period, locked, range_fault, gain_shift);
endinterface
`default_nettype wire

// *** rtl/resonance_tracker.sv ***
`timescale 1ns/10ps
`default_nettype none
module resonance_tracker
    import haptic_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // tracker link
    tracker_if.trk   t
);
    logic [14:0] per_r;
    logic        lock_r;
    logic        fault_r;
    logic [2:0]  shift_r;
    logic [15:0] err;
    logic [15:0] mag;
    logic [14:0] step;

    // signed error between measured and current period
    always_comb begin
        err = {1'b0, t.measured} - {1'b0, per_r};
        mag = err[15] ? (~err + 16'h0001) : err;
        step = mag[14:0] >> shift_r;
        if (step == 15'h0000 && mag != 16'h0000) begin
            step = 15'h0001;
        end
    end

    // period loop: follow when enabled, else hold programmed value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_r <= PER_RST;
        end else if (!t.enable || t.wideband) begin
            per_r <= t.nominal;
        end else if (t.meas_valid) begin
            // only follow measurements inside the loop range
            if (t.measured <= PER_50HZ && t.measured >= PER_300HZ) begin
                per_r <= err[15] ? per_r - step : per_r + step;
            end
        end
    end

    // lock indication
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= 1'b0;
        end else if (!t.enable) begin
            lock_r <= 1'b0;
        end else if (t.meas_valid && mag < 16'(LOCK_TOL)) begin
            lock_r <= 1'b1;
        end
    end

    // gain autoscale: finer gain only after first lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_r <= 3'h1;
        end else if (!t.enable || !t.autoscale || t.force_on) begin
            shift_r <= 3'h1;
        end else if (lock_r && t.meas_valid && shift_r != 3'h4) begin
            shift_r <= shift_r + 3'h1;
        end
    end

    // out of range fault, sticky while tracking without force on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_r <= 1'b0;
        end else if (!t.enable || t.force_on) begin
            fault_r <= 1'b0;
        end else if (t.meas_valid &&
                     (t.measured > PER_50HZ || t.measured < PER_300HZ)) begin
            fault_r <= 1'b1;
        end
    end

    assign t.period      = per_r;
    assign t.locked      = lock_r;
    assign t.range_fault = fault_r;
    assign t.gain_shift  = shift_r;
endmodule
`default_nettype wire

// *** rtl/haptic_drive_setup.sv ***
`timescale 1ns/10ps
`default_nettype none
module haptic_drive_setup
    import haptic_pkg::*;
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // actuator sense and drive
    input  wire logic [14:0] bemf_period,
    input  wire logic        bemf_valid,
    input  wire logic signed [7:0] drive_level,
    output logic [14:0]      drive_period,
    output logic signed [8:0] drive_cmd,
    output logic             drive_reverse,
    output logic             actuator_erm,
    output logic [7:0]       vlim_rms,
    output logic [7:0]       vlim_peak,
    output logic [4:0]       current_limit_code,
    output logic [15:0]      impedance_factor,
    output logic             boot_done,
    output logic             range_fault
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [5:0]  ctrl_r;
    logic        act_type_r;
    logic [7:0]  vrms_r;
    logic [7:0]  vpeak_r;
    logic [4:0]  ilim_r;
    logic [7:0]  imp_hi_r;
    logic [7:0]  imp_lo_r;
    logic [7:0]  per_hi_r;
    logic [6:0]  per_lo_r;
    logic [1:0]  mode_r;
    logic        wideband_r;
    logic [31:0] boot_cnt_r;
    dev_state_t  state_r;
    logic [7:0]  wmem_r [WMEM_DEPTH];
    logic [31:0] prdata_r;
    logic        pslverr_r;
    logic signed [7:0] last_level_r;
    logic [3:0]  od_cnt_r;
    logic signed [8:0] cmd_r;
    logic        rev_r;
    logic [14:0] drive_period_count;
    logic        wr_en;
    logic        rd_en;
    logic        wmem_hit;
    logic [7:0]  wmem_idx;
    logic        wmem_ok;

    tracker_if trk_bus ();

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic in_wmem(input logic [7:0] a);
        in_wmem = a >= OFF_WMEM &&
                  a < OFF_WMEM + 8'(WMEM_DEPTH);
    endfunction

    function automatic logic known(input logic [7:0] a);
        case (a)
            OFF_CTRL, OFF_ACT, OFF_VLIM, OFF_ILIM, OFF_IMPED, OFF_PER,
            OFF_STATUS, OFF_BEMF, OFF_WBASE, OFF_MODE: known = 1'b1;
            default: known = in_wmem(a);
        endcase
    endfunction

    assign drive_period_count = {per_hi_r, per_lo_r};
    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && penable && !pwrite;
    assign wmem_hit = in_wmem(paddr);
    assign wmem_idx = paddr - OFF_WMEM;
    // memory only reachable unlocked, inactive and after boot
    assign wmem_ok  = ctrl_r[CTRL_ACCESS] &&
                      state_r == ST_INACTIVE;

    // ------------------------------------------------------------
    // boot timer and device state
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cnt_r <= 32'h0000_0000;
            state_r    <= ST_BOOT;
        end else begin
            case (state_r)
                ST_BOOT: begin
                    boot_cnt_r <= boot_cnt_r + 32'h0000_0001;
                    if (boot_cnt_r == 32'(BOOT_CYCLES - 1)) begin
                        state_r <= ST_INACTIVE;
                    end
                end
                ST_INACTIVE: begin
                    if (mode_r != 2'(MODE_INACTIVE)) begin
                        state_r <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (mode_r == 2'(MODE_INACTIVE)) begin
                        state_r <= ST_INACTIVE;
                    end
                end
                default: state_r <= ST_BOOT;
            endcase
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= CTRL_RST;
            act_type_r <= 1'b0;
            vrms_r     <= 8'h00;
            vpeak_r    <= 8'h00;
            ilim_r     <= 5'h00;
            imp_hi_r   <= 8'h00;
            imp_lo_r   <= 8'h00;
            per_hi_r   <= PER_RST[14:7];
            per_lo_r   <= PER_RST[6:0];
            mode_r     <= 2'h0;
            wideband_r <= 1'b0;
        end else if (wr_en && state_r != ST_BOOT) begin
            case (paddr)
                OFF_CTRL:  ctrl_r     <= pwdata[5:0];
                OFF_ACT:   act_type_r <= pwdata[0];
                OFF_VLIM: begin
                    vrms_r  <= pwdata[7:0];
                    vpeak_r <= pwdata[15:8];
                end
                OFF_ILIM:  ilim_r     <= pwdata[4:0];
                OFF_IMPED: begin
                    imp_lo_r <= pwdata[7:0];
                    imp_hi_r <= pwdata[15:8];
                end
                OFF_PER: begin
                    per_lo_r <= pwdata[6:0];
                    per_hi_r <= pwdata[15:8];
                end
                OFF_MODE: begin
                    mode_r     <= pwdata[1:0];
                    wideband_r <= pwdata[4];
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // waveform memory, no reset so contents survive until power-on
    // ------------------------------------------------------------
    always_ff @(posedge pclk) begin
        if (wr_en && wmem_hit && wmem_ok) begin
            wmem_r[wmem_idx[WMEM_AW-1:0]] <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // apb read data and error answer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_r <= !known(paddr) ||
                         (in_wmem(paddr) && !wmem_ok);
            prdata_r  <= 32'h0000_0000;
            case (paddr)
                OFF_CTRL:   prdata_r <= {26'h0, ctrl_r};
                OFF_ACT:    prdata_r <= {31'h0, act_type_r};
                OFF_VLIM:   prdata_r <= {16'h0, vpeak_r, vrms_r};
                OFF_ILIM:   prdata_r <= {27'h0, ilim_r};
                OFF_IMPED:  prdata_r <= {16'h0, imp_hi_r, imp_lo_r};
                OFF_PER:    prdata_r <= {16'h0, per_hi_r, 1'b0, per_lo_r};
                OFF_STATUS: prdata_r <= {24'h0, 1'b0, trk_bus.gain_shift,
                                         trk_bus.range_fault,
                                         trk_bus.locked,
                                         state_r == ST_ACTIVE,
                                         state_r != ST_BOOT};
                OFF_BEMF:   prdata_r <= {17'h0, trk_bus.period};
                OFF_WBASE:  prdata_r <= {24'h0, WMEM_BASE};
                OFF_MODE:   prdata_r <= {27'h0, wideband_r, 2'h0, mode_r};
                default: begin
                    if (in_wmem(paddr) && wmem_ok) begin
                        prdata_r <= {24'h0,
                            wmem_r[wmem_idx[WMEM_AW-1:0]]};
                    end
                end
            endcase
        end
    end

    assign pready  = 1'b1;
    assign prdata  = rd_en ? prdata_r : 32'h0000_0000;
    assign pslverr = psel && penable && pslverr_r;

    // ------------------------------------------------------------
    // tracker hookup; wideband turns tracking off
    // ------------------------------------------------------------
    assign trk_bus.enable     = ctrl_r[CTRL_TRACK] && !act_type_r &&
                                !wideband_r;
    assign trk_bus.autoscale  = ctrl_r[CTRL_AUTOSCALE];
    assign trk_bus.force_on   = ctrl_r[CTRL_FORCE_ON];
    assign trk_bus.wideband   = wideband_r;
    assign trk_bus.nominal    = drive_period_count;
    assign trk_bus.measured   = bemf_period;
    assign trk_bus.meas_valid = bemf_valid && state_r == ST_ACTIVE;

    resonance_tracker u_trk (
        .pclk    (pclk),
        .presetn (presetn),
        .t       (trk_bus)
    );

    // ------------------------------------------------------------
    // overdrive on level change while tracking is enabled, and reverse braking
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_level_r <= 8'sh00;
            od_cnt_r     <= 4'h0;
            cmd_r        <= 9'sh000;
            rev_r        <= 1'b0;
        end else begin
            last_level_r <= drive_level;
            if (od_cnt_r != 4'h0) begin
                od_cnt_r <= od_cnt_r - 4'h1;
            end
            if (ctrl_r[CTRL_BRAKE] && drive_level == 8'sh00 &&
                last_level_r != 8'sh00) begin
                // full reverse: phase flip or polarity inversion
                cmd_r <= -9'(last_level_r) * 9'sd2;
                rev_r <= 1'b1;
                od_cnt_r <= 4'hf;
            end else if (ctrl_r[CTRL_OVERDRIVE] && trk_bus.enable &&
                         drive_level != last_level_r) begin
                // double the step toward the new level
                cmd_r <= 9'(drive_level) * 9'sd2 - 9'(last_level_r);
                rev_r <= drive_level < last_level_r;
                od_cnt_r <= 4'hf;
            end else if (od_cnt_r == 4'h0) begin
                cmd_r <= 9'(drive_level);
                rev_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs; for rotating mass the period paces sensing
    // ------------------------------------------------------------
    assign drive_period       = trk_bus.period;
    assign drive_cmd          = cmd_r;
    assign drive_reverse      = rev_r;
    assign actuator_erm       = act_type_r;
    assign vlim_rms           = vrms_r;
    assign vlim_peak          = vpeak_r;
    assign current_limit_code = ilim_r;
    assign impedance_factor   = {imp_hi_r, imp_lo_r};
    assign boot_done          = state_r != ST_BOOT;
    assign range_fault        = trk_bus.range_fault;
endmodule
`default_nettype wire

// *** verif/haptic_drive_setup_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module haptic_drive_setup_checker
    import haptic_pkg::*;
(
    // apb side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // actuator side
    input wire logic [14:0] drive_period,
    input wire logic        drive_reverse,
    input wire logic        actuator_erm,
    input wire logic [7:0]  vlim_rms,
    input wire logic [7:0]  vlim_peak,
    input wire logic [4:0]  current_limit_code,
    input wire logic [15:0] impedance_factor,
    input wire logic        boot_done,
    input wire logic        range_fault
);
    logic        wr;
    logic [5:0]  ctl_r;
    logic [14:0] per_r;
    logic [16:0] cnt_r;
    // accepted register write
    assign wr = psel && penable && pwrite && pready && boot_done;
    // shadow of control and period writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r <= 6'h00;
            per_r <= 15'h0000;
        end else if (wr && paddr == OFF_CTRL) begin
            ctl_r <= pwdata[5:0];
        end else if (wr && paddr == OFF_PER) begin
            per_r <= {pwdata[15:8], pwdata[6:0]};
        end
    end
    // cycles since reset release, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_r <= 17'h00000;
        else if (cnt_r != 17'h1ffff)
            cnt_r <= cnt_r + 17'h00001;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    AST_BOOT_EARLY: assert property (
        cnt_r < BOOT_CYCLES - 2 |-> !boot_done)
        else $error("boot done too early");
    AST_BOOT_LATE: assert property (
        cnt_r > BOOT_CYCLES + 2 |-> boot_done)
        else $error("boot not done in time");
    AST_ERM: assert property (
        wr && paddr == OFF_ACT |=> actuator_erm == $past(pwdata[0]))
        else $error("actuator type not taken");
    AST_VLIM: assert property (
        wr && paddr == OFF_VLIM
        |=> {vlim_peak, vlim_rms} == $past(pwdata[15:0]))
        else $error("voltage limits not taken");
    AST_ILIM: assert property (
        wr && paddr == OFF_ILIM
        |=> current_limit_code == $past(pwdata[4:0]))
        else $error("current limit not taken");
    AST_IMPED: assert property (
        wr && paddr == OFF_IMPED
        |=> impedance_factor == $past(pwdata[15:0]))
        else $error("impedance factor not taken");
    AST_PERIOD: assert property (
        wr && paddr == OFF_PER && !ctl_r[CTRL_TRACK]
        |=> ##[0:3] drive_period == per_r)
        else $error("written period not adopted");
    AST_HOLD: assert property (
        (!ctl_r[CTRL_TRACK] && !(wr && paddr == OFF_PER)) [*5]
        |-> $stable(drive_period))
        else $error("period moved with tracking off");
    AST_FORCE: assert property (
        ctl_r[CTRL_FORCE_ON] [*3] |-> !range_fault)
        else $error("fault raised under force on");
    AST_FAULT_SRC: assert property (
        $rose(range_fault) |-> ctl_r[CTRL_TRACK])
        else $error("fault without tracking");
    AST_REV: assert property (
        $rose(drive_reverse) |-> ctl_r[CTRL_BRAKE])
        else $error("reverse drive without braking");
    AST_MEM: assert property (
        psel && penable && boot_done && !ctl_r[CTRL_ACCESS]
        && paddr >= OFF_WMEM && paddr < 8'ha4 |-> pslverr)
        else $error("memory reached while locked");
endmodule
bind haptic_drive_setup haptic_drive_setup_checker i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .drive_period(drive_period),
    .drive_reverse(drive_reverse), .actuator_erm(actuator_erm),
    .vlim_rms(vlim_rms), .vlim_peak(vlim_peak),
    .current_limit_code(current_limit_code),
    .impedance_factor(impedance_factor), .boot_done(boot_done),
    .range_fault(range_fault));
`default_nettype wire

// *** verif/actuator_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module actuator_model (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // resonance and pace set by the bench
    input  wire logic [14:0] res_period,
    input  wire logic        slow,
    // back-emf report
    output logic [14:0]      bemf_period,
    output logic             bemf_valid
);
    logic [7:0] cnt_r;
    logic       due;
    // a report every 64 cycles, or every 256 when slow
    assign due = slow ? (cnt_r == 8'hff) : (cnt_r[5:0] == 6'h3f);
    // between reports the value is scrambled, never held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r       <= 8'h00;
            bemf_valid  <= 1'b0;
            bemf_period <= 15'h0000;
        end else begin
            cnt_r       <= cnt_r + 8'h01;
            bemf_valid  <= due;
            bemf_period <= due ? res_period : ~bemf_period;
        end
    end
endmodule
`default_nettype wire

// *** verif/test_haptic_drive_setup.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_haptic_drive_setup
    import haptic_pkg::*;
;
    logic              pclk = 1'b0;
    logic              presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]        paddr, vlim_rms, vlim_peak;
    logic [31:0]       pwdata, prdata, rd;
    logic              er, bemf_valid, drive_reverse, actuator_erm;
    logic              boot_done, range_fault, slow;
    logic [14:0]       bemf_period, drive_period, res_period;
    logic signed [7:0] drive_level;
    logic signed [8:0] drive_cmd;
    logic [4:0]        current_limit_code;
    logic [15:0]       impedance_factor;
    int                mismatches, checked, n;
    // 50 MHz clock
    always #10 pclk = ~pclk;
    haptic_drive_setup i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bemf_period(bemf_period), .bemf_valid(bemf_valid),
        .drive_level(drive_level), .drive_period(drive_period),
        .drive_cmd(drive_cmd), .drive_reverse(drive_reverse),
        .actuator_erm(actuator_erm), .vlim_rms(vlim_rms),
        .vlim_peak(vlim_peak), .current_limit_code(current_limit_code),
        .impedance_factor(impedance_factor), .boot_done(boot_done),
        .range_fault(range_fault));
    actuator_model i_act (.pclk(pclk), .presetn(presetn),
        .res_period(res_period), .slow(slow), .bemf_period(bemf_period),
        .bemf_valid(bemf_valid));
    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic tick(input int c);
        repeat (c) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        if (k >= 50) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input logic ee);
        apb(1'b0, a, 32'h0);
        `CHK("prdata", e, rd)
        `CHK("pslverr", ee, er)
    endtask
    task automatic results;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog sized above boot plus all tests
    initial begin
        tick(95000);
        mismatches++;
        results();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        drive_level = 8'sh00;
        res_period = PER_RST;
        slow = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, OFF_ACT, 32'h1);
        for (n = 0; n < 80000 && boot_done !== 1'b1; n++) tick(1);
        `CHK("boot", 1'b1, n > BOOT_CYCLES - 10 && n <= BOOT_CYCLES)
        rchk(OFF_ACT, 32'h0, 1'b0);
        rchk(OFF_PER, 32'h1d26, 1'b0);
        $display("test boot done");
        apb(1'b1, OFF_ACT, 32'h1);
        apb(1'b1, OFF_VLIM, 32'hff01);
        apb(1'b1, OFF_ILIM, 32'hff);
        apb(1'b1, OFF_IMPED, 32'h8001);
        tick(1);
        `CHK("erm", 1'b1, actuator_erm)
        `CHK("vlim", 16'hff01, {vlim_peak, vlim_rms})
        `CHK("ilim", 5'h1f, current_limit_code)
        `CHK("imped", 16'h8001, impedance_factor)
        rchk(OFF_IMPED, 32'h8001, 1'b0);
        rchk(8'h30, 32'h0, 1'b1);
        apb(1'b1, OFF_ACT, 32'h0);
        tick(1);
        `CHK("erm", 1'b0, actuator_erm)
        $display("test config done");
        apb(1'b1, OFF_MODE, 32'h11);
        for (n = 0; n < 2; n++) begin
            apb(1'b1, OFF_PER, n ? 32'hea30 : 32'h056e);
            tick(3);
            `CHK("period", n ? PER_25HZ : PER_1000HZ, drive_period)
        end
        tick(200);
        `CHK("period", PER_25HZ, drive_period)
        $display("test wideband done");
        apb(1'b1, OFF_MODE, 32'h1);
        apb(1'b1, OFF_PER, 32'h1d26);
        res_period <= 15'd4500;
        apb(1'b1, OFF_CTRL, 32'h3);
        rchk(OFF_STATUS, 32'h13, 1'b0);
        for (n = 0; n < 15000 && (drive_period >= 4500 - LOCK_TOL &&
             drive_period <= 4500 + LOCK_TOL) !== 1'b1; n++) tick(1);
        `CHK("lock", 1'b1, n < 15000)
        tick(150);
        apb(1'b0, OFF_STATUS, 32'h0);
        `CHK("locked", 1'b1, rd[2])
        slow <= 1'b1;
        res_period <= 15'd2000;
        for (n = 0; n < 8000 && range_fault !== 1'b1; n++) tick(1);
        `CHK("fault", 1'b1, range_fault)
        apb(1'b1, OFF_CTRL, 32'h7);
        tick(3);
        `CHK("fault", 1'b0, range_fault)
        $display("test tracking done");
        slow = 1'b0;
        res_period = PER_RST;
        apb(1'b1, OFF_CTRL, 32'h19);
        @(posedge pclk);
        drive_level <= 8'sd40;
        for (n = 0; n < 40 && (drive_cmd > 9'sd40) !== 1'b1; n++) tick(1);
        `CHK("overdrive", 1'b1, n < 40)
        repeat (40) @(posedge pclk);
        drive_level <= 8'sd0;
        for (n = 0; n < 40 && drive_reverse !== 1'b1; n++) tick(1);
        `CHK("brake", 1'b1, n < 40)
        $display("test drive done");
        apb(1'b1, OFF_MODE, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h0);
        rchk(OFF_WBASE, {24'h0, WMEM_BASE}, 1'b0);
        apb(1'b1, OFF_WMEM, 32'h5a);
        `CHK("locked_wr", 1'b1, er)
        apb(1'b1, OFF_CTRL, 32'h20);
        for (n = 0; n < 2; n++) begin
            apb(1'b1, OFF_WMEM, 32'h5a + n);
            apb(1'b1, 8'ha3, 32'ha5 - n);
        end
        rchk(8'ha3, 32'ha4, 1'b0);
        rchk(8'ha4, 32'h0, 1'b1);
        apb(1'b1, OFF_MODE, 32'h1);
        apb(1'b1, OFF_WMEM, 32'h11);
        `CHK("active_wr", 1'b1, er)
        apb(1'b1, OFF_MODE, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h0);
        rchk(OFF_WMEM, 32'h0, 1'b1);
        apb(1'b1, OFF_CTRL, 32'h20);
        rchk(OFF_WMEM, 32'h5b, 1'b0);
        $display("test memory done");
        results();
    end
endmodule
`default_nettype wire
